// file: rtl/crr_result_bank.sv
/*
 Read-only bank of 10-bit conversion results, split into upper and
 packed lower registers. Assumes the serial front end presents one
 decoded request per cycle and the converter core one update per cycle.
*/
`timescale 1ns/1ps
`include "crr_consts.svh"
module crr_result_bank
  import crr_pkg::*;
#(
  parameter int NUM_CH = 11
) (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  crr_pkg::crr_update_t upd_i,
  input  crr_pkg::crr_req_t    req_i,
  input  wire logic [7:0]  cfg1_i,
  output logic [7:0]       rdata_o,
  output logic             rvalid_o,
  output logic             hit_o
);
  import crr_pkg::*;

  // ---------------------------------------------------------------
  // Result storage
  // ---------------------------------------------------------------
  crr_result_t res_r [NUM_CH];
  logic        ext_sel;

  // Both config bits clear selects the external sensor
  assign ext_sel = ~cfg1_i[`CRR_CFG_SEL_LO] & ~cfg1_i[`CRR_CFG_SEL_HI];

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_res
      logic hit_ch;
      assign hit_ch = upd_i.valid && (upd_i.chan == 4'(g));
      // Writes never reach storage: only the converter loads it
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          res_r[g] <= `CRR_RST_RESULT;
        end else if (hit_ch) begin
          res_r[g] <= upd_i.value;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  crr_result_t ext_res;
  logic [7:0]  lo03;
  logic [7:0]  lo04;
  logic [7:0]  lo05;
  logic [7:0]  rd_mux;
  logic        mapped;
  logic [7:0]  a;

  assign a       = req_i.addr;
  assign ext_res = ext_sel ? res_r[CRR_CH_EXT] : res_r[CRR_CH_IN1];
  assign lo03    = {4'h0, res_r[CRR_CH_SUPPLY][1:0],
                    res_r[CRR_CH_TEMP][1:0]};
  assign lo04    = {res_r[CRR_CH_IN4][1:0], res_r[CRR_CH_IN3][1:0],
                    res_r[CRR_CH_IN2][1:0], ext_res[1:0]};
  assign lo05    = {res_r[CRR_CH_IN8][1:0], res_r[CRR_CH_IN7][1:0],
                    res_r[CRR_CH_IN6][1:0], res_r[CRR_CH_IN5][1:0]};
  assign mapped  = (a >= `CRR_OFS_TEMP_SUP_LO) && (a <= `CRR_OFS_IN8_HI);

  always_comb begin
    case (a)
      `CRR_OFS_TEMP_SUP_LO: rd_mux = lo03;
      `CRR_OFS_EXT_IN_LO:   rd_mux = lo04;
      `CRR_OFS_UPPER_LO:    rd_mux = lo05;
      `CRR_OFS_SUPPLY_HI:   rd_mux = res_r[CRR_CH_SUPPLY][9:2];
      `CRR_OFS_TEMP_HI:     rd_mux = res_r[CRR_CH_TEMP][9:2];
      `CRR_OFS_EXT_HI:      rd_mux = ext_res[9:2];
      `CRR_OFS_IN2_HI:      rd_mux = res_r[CRR_CH_IN2][9:2];
      8'h0a:                rd_mux = res_r[CRR_CH_IN3][9:2];
      8'h0b:                rd_mux = res_r[CRR_CH_IN4][9:2];
      `CRR_OFS_IN5_HI:      rd_mux = res_r[CRR_CH_IN5][9:2];
      8'h0d:                rd_mux = res_r[CRR_CH_IN6][9:2];
      8'h0e:                rd_mux = res_r[CRR_CH_IN7][9:2];
      `CRR_OFS_IN8_HI:      rd_mux = res_r[CRR_CH_IN8][9:2];
      default:              rd_mux = `CRR_RST_BYTE;
    endcase
  end

  // ---------------------------------------------------------------
  // Registered read answer
  // ---------------------------------------------------------------
  // Answer one cycle after the read; unmapped reads give zero
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o  <= `CRR_RST_BYTE;
      rvalid_o <= 1'b0;
      hit_o    <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      hit_o    <= req_i.rd && mapped;
      if (req_i.rd) begin
        rdata_o <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Reads guarded against a same-cycle load, which the read misses

  AST_LO03_LAYOUT: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == `CRR_OFS_TEMP_SUP_LO && !upd_i.valid |=>
    rdata_o == {4'h0, res_r[1][1:0], res_r[0][1:0]})
    else $error("low register 03h layout wrong");

  AST_LO03_UNUSED: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == `CRR_OFS_TEMP_SUP_LO |=>
    rdata_o[7:4] == 4'h0)
    else $error("unused bits of 03h not zero");

  AST_EXT_SEL: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == `CRR_OFS_EXT_IN_LO && !upd_i.valid |=>
    rdata_o[1:0] == ($past(ext_sel) ? res_r[2][1:0] : res_r[3][1:0]))
    else $error("04h low pair from wrong source");

  AST_SEL_BITS: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    ext_sel == !(cfg1_i[1] || cfg1_i[2]))
    else $error("source select ignores config bits");

  AST_LO04_EXT: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == `CRR_OFS_EXT_IN_LO && !upd_i.valid &&
    !cfg1_i[1] && !cfg1_i[2] |=>
    rdata_o[1:0] == res_r[CRR_CH_EXT][1:0])
    else $error("04h low pair not external with bits clear");

  AST_LO04_IN1: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == `CRR_OFS_EXT_IN_LO && !upd_i.valid &&
    (cfg1_i[1] || cfg1_i[2]) |=>
    rdata_o[1:0] == res_r[CRR_CH_IN1][1:0])
    else $error("04h low pair not input one with a bit set");

  AST_LO04_PAIRS: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == `CRR_OFS_EXT_IN_LO && !upd_i.valid |=>
    rdata_o[7:2] == {res_r[6][1:0], res_r[5][1:0], res_r[4][1:0]})
    else $error("04h input pairs wrong");

  AST_LO05_PAIRS: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == `CRR_OFS_UPPER_LO && !upd_i.valid |=>
    rdata_o == {res_r[10][1:0], res_r[9][1:0],
                res_r[8][1:0], res_r[7][1:0]})
    else $error("05h pairs wrong");

  AST_IN5_HI: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == `CRR_OFS_IN5_HI && !upd_i.valid |=>
    rdata_o == res_r[7][9:2])
    else $error("input five upper byte wrong");

  AST_IN6_HI: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == 8'h0d && !upd_i.valid |=>
    rdata_o == res_r[CRR_CH_IN6][9:2])
    else $error("input six upper byte wrong");

  AST_IN7_HI: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == 8'h0e && !upd_i.valid |=>
    rdata_o == res_r[CRR_CH_IN7][9:2])
    else $error("input seven upper byte wrong");

  AST_IN8_HI: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == `CRR_OFS_IN8_HI && !upd_i.valid |=>
    rdata_o == res_r[CRR_CH_IN8][9:2])
    else $error("input eight upper byte wrong");

  AST_SUPPLY_HI: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    upd_i.valid && upd_i.chan == 4'h1 ##1 req_i.rd &&
    a == `CRR_OFS_SUPPLY_HI && !upd_i.valid |=>
    rdata_o == $past(upd_i.value, 2) >> 2)
    else $error("supply upper byte not loaded");

  AST_SUPPLY_READ: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == `CRR_OFS_SUPPLY_HI && !upd_i.valid |=>
    rdata_o == res_r[CRR_CH_SUPPLY][9:2])
    else $error("supply upper byte wrong");

  AST_TEMP_HI: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == `CRR_OFS_TEMP_HI && !upd_i.valid |=>
    rdata_o == res_r[0][9:2])
    else $error("temperature upper byte wrong");

  AST_TEMP_LOAD: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    upd_i.valid && upd_i.chan == 4'h0 |=>
    res_r[CRR_CH_TEMP] == $past(upd_i.value))
    else $error("temperature load lost");

  AST_LOAD_ISOLATED: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    upd_i.valid && upd_i.chan == 4'h0 |=>
    $stable(res_r[CRR_CH_SUPPLY]) && $stable(res_r[CRR_CH_IN8]))
    else $error("temperature load spilled to another channel");

  AST_EXT_LOAD: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    upd_i.valid && upd_i.chan == 4'h2 |=>
    res_r[CRR_CH_EXT] == $past(upd_i.value))
    else $error("external temperature load lost");

  AST_EXT_HI: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == `CRR_OFS_EXT_HI && !upd_i.valid |=>
    rdata_o == ($past(ext_sel) ? res_r[CRR_CH_EXT][9:2]
                               : res_r[CRR_CH_IN1][9:2]))
    else $error("external upper byte wrong");

  AST_IN2_HI: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == `CRR_OFS_IN2_HI && !upd_i.valid |=>
    rdata_o == res_r[4][9:2])
    else $error("input two upper byte wrong");

  AST_IN3_HI: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == 8'h0a && !upd_i.valid |=>
    rdata_o == res_r[CRR_CH_IN3][9:2])
    else $error("input three upper byte wrong");

  AST_IN4_HI: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && a == 8'h0b && !upd_i.valid |=>
    rdata_o == res_r[CRR_CH_IN4][9:2])
    else $error("input four upper byte wrong");

  AST_WRITE_IGNORED: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.wr && !upd_i.valid |=> $stable(res_r[0]) && $stable(res_r[4]))
    else $error("host write changed a result");

  AST_WRITE_KEEPS_UPPER: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.wr && !upd_i.valid |=>
    $stable(res_r[CRR_CH_IN5]) && $stable(res_r[CRR_CH_IN8]))
    else $error("host write changed an upper input");

  AST_WRITE_NO_ANSWER: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.wr && !req_i.rd |=> !rvalid_o && $stable(rdata_o))
    else $error("host write produced an answer");

  AST_UNMAPPED_ZERO: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && !mapped |=> rdata_o == 8'h00 && !hit_o)
    else $error("unmapped read not zero");

  AST_RVALID_FOLLOWS: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd |=> rvalid_o)
    else $error("read gave no answer strobe");

  AST_RVALID_PULSE: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    !req_i.rd |=> !rvalid_o)
    else $error("answer strobe without a read");

  AST_HIT_MAPPED: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    req_i.rd && mapped |=> hit_o)
    else $error("mapped read not flagged");

  AST_HIT_WITH_VALID: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    hit_o |-> rvalid_o)
    else $error("hit flag without answer strobe");

  AST_RDATA_HOLD: assert property (
    @(posedge core_clk_i) disable iff (!nrst_i)
    !req_i.rd |=> $stable(rdata_o))
    else $error("read data moved without a read");
endmodule

// file: rtl/crr_consts.svh
/*
 Offsets, field positions and reset values of the result bank.
 Assumes inclusion from the package and the bank module only.
*/
`ifndef CRR_CONSTS_SVH
`define CRR_CONSTS_SVH

`define CRR_OFS_TEMP_SUP_LO  8'h03
`define CRR_OFS_EXT_IN_LO    8'h04
`define CRR_OFS_UPPER_LO     8'h05
`define CRR_OFS_SUPPLY_HI    8'h06
`define CRR_OFS_TEMP_HI      8'h07
`define CRR_OFS_EXT_HI       8'h08
`define CRR_OFS_IN2_HI       8'h09
`define CRR_OFS_IN5_HI       8'h0c
`define CRR_OFS_IN8_HI       8'h0f

`define CRR_CFG_SEL_LO       1
`define CRR_CFG_SEL_HI       2
`define CRR_RST_RESULT       10'h000
`define CRR_RST_SUPPLY       10'h000
`define CRR_RST_BYTE         8'h00

`endif

// file: rtl/crr_pkg.sv
/*
 Types of the conversion result bank.
 Assumes the constants header sits beside it in rtl/.
*/
package crr_pkg;
  `include "crr_consts.svh"

  typedef logic [9:0] crr_result_t;

  // One conversion update from the converter core
  typedef struct packed {
    logic        valid;
    logic [3:0]  chan;
    crr_result_t value;
  } crr_update_t;

  // Host register read/write request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crr_req_t;

  typedef enum logic [3:0] {
    CRR_CH_TEMP   = 4'h0,
    CRR_CH_SUPPLY = 4'h1,
    CRR_CH_EXT    = 4'h2,
    CRR_CH_IN1    = 4'h3,
    CRR_CH_IN2    = 4'h4,
    CRR_CH_IN3    = 4'h5,
    CRR_CH_IN4    = 4'h6,
    CRR_CH_IN5    = 4'h7,
    CRR_CH_IN6    = 4'h8,
    CRR_CH_IN7    = 4'h9,
    CRR_CH_IN8    = 4'ha
  } crr_chan_t;
endpackage

// file: test/crr_host_model.sv
/*
 Host side of the result bank: one register access per call.
 Assumes the bank answers exactly one cycle after the request edge.
*/
`timescale 1ns/1ps
module crr_host_model
  import crr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic [7:0]  rdata_i,
  input  wire logic        rvalid_i,
  input  wire logic        hit_i,
  output crr_pkg::crr_req_t req_o
);
  initial req_o = '0;
  // Answer is {valid, hit, data}, taken at the answer edge
  task automatic access(input logic wr, input logic [7:0] addr,
                        output logic [9:0] ans);
    @(posedge clk_i);
    req_o <= '{rd: !wr, wr: wr, addr: addr, wdata: 8'hff};
    @(posedge clk_i);
    req_o <= '0;
    @(posedge clk_i);
    ans = {rvalid_i, hit_i, rdata_i};
  endtask
endmodule

// file: test/crr_result_bank_tb_top.sv
/*
 Self-checking bench of the result bank, table loop then edge cases.
 Assumes the host model and the bank share one 125 MHz clock.
*/
`timescale 1ns/1ps
module crr_result_bank_tb_top;
  import crr_pkg::*;
  logic        core_clk = 1'b0;
  logic        nrst     = 1'b0;
  crr_update_t upd      = '0;
  crr_req_t    req;
  logic [7:0]  cfg      = 8'h00;
  logic [7:0]  rdata;
  logic        rvalid, hit;
  logic [9:0]  ans, lo, v;
  logic [23:0] r;
  int          mismatches = 0, total_checks = 0, cycles = 0;
  // Row: channel, low addr, pair shift, upper addr, config
  logic [23:0] rows [13] = '{24'h030700, 24'h132600, 24'h240800,
    24'h340802, 24'h340804, 24'h340806, 24'h442900, 24'h544a00,
    24'h646b00, 24'h750c00, 24'h852d00, 24'h954e00, 24'ha56f00};

  always #4 core_clk = ~core_clk;

  crr_result_bank crr_result_bank_i (.core_clk_i(core_clk),
    .nrst_i(nrst), .upd_i(upd), .req_i(req), .cfg1_i(cfg),
    .rdata_o(rdata), .rvalid_o(rvalid), .hit_o(hit));
  crr_host_model crr_host_model_i (.clk_i(core_clk), .rdata_i(rdata),
    .rvalid_i(rvalid), .hit_i(hit), .req_o(req));

  function automatic logic [9:0] val(input logic [3:0] c);
    return 10'h1c6 + 10'h05b * {6'h00, c};
  endfunction
  task automatic check(input string what, input logic [9:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a);
    crr_host_model_i.access(wr, a, ans);
  endtask
  task automatic load(input logic [3:0] c);
    @(posedge core_clk);
    upd <= '{valid: 1'b1, chan: c, value: val(c)};
    @(posedge core_clk);
    upd <= '0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard, far above the 172 cycles the run needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    check("reset outputs", {rvalid, hit, rdata}, 10'h000);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      xfer(1'b0, {4'h0, rows[i][11:8]});
      check("reset upper", ans, 10'h300);
    end
    $display("test reset done");
    for (int c = 0; c < 11; c++) load(4'(c));
    foreach (rows[i]) begin
      r = rows[i];
      v = val(r[23:20]);
      cfg <= r[7:0];
      xfer(1'b0, {4'h0, r[19:16]});
      lo = ans;
      xfer(1'b0, {4'h0, r[11:8]});
      check("answer flags", {ans[9:8], lo[9:8]}, 10'h00f);
      check("rebuilt", {ans[7:0], lo[r[15:12] +: 2]}, v);
    end
    xfer(1'b0, 8'h03);
    check("unused bits", {6'h00, ans[7:4]}, 10'h000);
    $display("test table done");
    xfer(1'b1, 8'h07);
    check("write answer", ans[9:8], 10'h000);
    xfer(1'b0, 8'h07);
    check("after write", ans[7:0], {2'b00, val(4'h0) >> 2});
    xfer(1'b0, 8'h10);
    check("unmapped", ans, 10'h200);
    $display("test write done");
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("second reset outputs", {rvalid, hit, rdata}, 10'h000);
    nrst <= 1'b1;
    xfer(1'b0, 8'h05);
    check("second reset", ans, 10'h300);
    $display("test second reset done");
    end_of_test();
  end
endmodule
